// File: hw/acs_defines.svh
// Register map, field positions, reset values and timing counts
// Operation
// R1: Cleared select bit makes pin digital only
// R2: Set select bit: analog, digital off, reads zero
// R3: Reset sets every analog select bit
// R4: Low config bits 7-0 map channels 7-0
// R5: High config bits 6-0 map 14-8; bit7 zero
// R6: Small package: some bits writable but ineffective
// R7: Reference selectable: supplies, pins, 2.0V, 4.1V
// R8: Sleep conversion requires RC conversion clock
// R9: Completion loads result, clears go, sets done
// R10: Reset restores registers, aborts conversion, converter off
// R11: Power-on reset leaves result pair untouched
// R12: Software configures, enables, sets go, reads result
// R13: Software polls go or waits done flag
// R14: Two conversion clocks wait before next acquisition
// R15: Hold capacitor isolated during whole conversion
// R16: Software ensures acquisition time before start
// R17: Acquisition code zero: go starts conversion immediately
// R18: Nonzero code: sample programmed periods, then convert
// R19: After completion clear go, set done, resample
// R20: No status separates acquisition from conversion
// R21: Successive approximation on held sample
// R22: Channel code 28 opens all mux switches
// R23: Conversion takes fourteen conversion clock periods
// R24: Acquisition codes give 0,2,4,6,8,12,16,20 periods
// R25: Clock codes: /2,/8,/32,RC,/4,/16,/64,RC
// R26: Clearing go aborts; result keeps last value
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

`define ACS_OFS_CTRL0          8'h00
`define ACS_OFS_CTRL1          8'h04
`define ACS_OFS_CTRL2          8'h08
`define ACS_OFS_RES_HIGH       8'h0C
`define ACS_OFS_RES_LOW        8'h10
`define ACS_OFS_PIN_LOW        8'h14
`define ACS_OFS_PIN_HIGH       8'h18
`define ACS_OFS_FLAGS          8'h1C

`define ACS_BIT_ON             0
`define ACS_BIT_GO             1
`define ACS_BIT_DONE           0

`define ACS_RST_CTRL           8'h00
`define ACS_RST_PIN_LOW        8'hFF
`define ACS_RST_PIN_HIGH       8'h7F
`define ACS_PIN_HIGH_MASK      8'h7F
`define ACS_SMALL_PKG_MASK     15'h78E0
`define ACS_MUX_OPEN_CODE      5'h1C

`define ACS_CONV_TADS          4'hE
`define ACS_WAIT_TADS          5'h02
`define ACS_SAR_BITS           4'hC
`define ACS_SAR_TOP            12'h800

`endif

// File: hw/acs_pkg.sv
// Types shared by the converter sequencer
package acs_pkg;

    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_ACQ  = 2'b01,
        ACS_CONV = 2'b10,
        ACS_WAIT = 2'b11
    } acs_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
    } acs_bus_req_t;

    typedef struct packed {
        logic        sample;
        logic [4:0]  pos_ch;
        logic        mux_open;
        logic [2:0]  neg_ch;
        logic [1:0]  vref_pos;
        logic        vref_neg;
        logic [11:0] dac;
    } acs_ana_t;

endpackage

// File: hw/acs_top.sv
// Converter sequencer, pin configuration and AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "acs_defines.svh"

module acs_top
    import acs_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        small_pkg,
    input  wire logic        sleep_mode,
    input  wire logic        rc_tick,
    input  wire logic        cmp_in,
    input  wire logic [14:0] pin_din,
    output logic      [14:0] pin_dig_rd,
    output logic      [14:0] pin_analog_en,
    output logic      [14:0] pin_dig_en,
    output acs_ana_t         ana,
    output logic             conversion_done_flag
);

    acs_bus_req_t req_r;
    acs_state_t   st_r;
    logic [7:0]   ctrl0_r;
    logic [7:0]   ctrl1_r;
    logic [7:0]   ctrl2_r;
    logic [7:0]   pin_low_r;
    logic [7:0]   pin_high_r;
    logic [7:0]   conversion_result_high_r;
    logic [7:0]   conversion_result_low_r;
    logic         done_r;
    logic         rd_wait_r;
    logic [31:0]  hrdata_r;
    logic [5:0]   div_r;
    logic [4:0]   tad_cnt_r;
    logic [11:0]  sar_r;
    logic         tad_tick;
    logic         conv_end;
    logic         run_ok;
    logic         wr_fire;
    logic [7:0]   wdat;
    logic [14:0]  sel_eff;
    logic [2:0]   acquisition_time_select;
    logic [2:0]   conversion_clock_select;
    logic [15:0]  res_word;

    // Divider terminal count per clock code, RC codes unused
    function automatic logic [5:0] tad_limit(input logic [2:0] code);
        logic [5:0] lim;
        lim = 6'h01;
        unique case (code)
            3'b000:  lim = 6'h01;
            3'b001:  lim = 6'h07;
            3'b010:  lim = 6'h1F;
            3'b100:  lim = 6'h03;
            3'b101:  lim = 6'h0F;
            3'b110:  lim = 6'h3F;
            default: lim = 6'h01;
        endcase
        return lim;
    endfunction

    // Acquisition periods per code
    function automatic logic [4:0] acq_tads(input logic [2:0] code);
        logic [4:0] n;
        n = 5'h00;
        unique case (code)
            3'b000: n = 5'h00;
            3'b001: n = 5'h02;
            3'b010: n = 5'h04;
            3'b011: n = 5'h06;
            3'b100: n = 5'h08;
            3'b101: n = 5'h0C;
            3'b110: n = 5'h10;
            3'b111: n = 5'h14;
        endcase
        return n;
    endfunction

    assign acquisition_time_select    = ctrl2_r[5:3];
    assign conversion_clock_select    = ctrl2_r[2:0];
    assign wr_fire = req_r.wr;
    assign wdat    = hwdata[7:0];

    // Bus address phase capture; writes are acted on only at word size, reads at any size
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r <= '0;
        end else if (ce && hreadyout) begin
            req_r.wr   <= hsel && htrans[1] && hready && hwrite
                          && (hsize == 3'b010);
            req_r.rd   <= hsel && htrans[1] && hready && !hwrite;
            req_r.addr <= haddr[7:0];
        end
    end

    // Reads take one wait state so the word reflects the last write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait_r <= 1'b0;
        end else if (ce) begin
            rd_wait_r <= req_r.rd && !rd_wait_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (ce && req_r.rd && !rd_wait_r) begin
            hrdata_r <= 32'h0000_0000;
            unique case (req_r.addr)
                `ACS_OFS_CTRL0:    hrdata_r[7:0] <= ctrl0_r;
                `ACS_OFS_CTRL1:    hrdata_r[7:0] <= ctrl1_r;
                `ACS_OFS_CTRL2:    hrdata_r[7:0] <= ctrl2_r & 8'hBF;
                `ACS_OFS_RES_HIGH: hrdata_r[7:0] <= conversion_result_high_r;
                `ACS_OFS_RES_LOW:  hrdata_r[7:0] <= conversion_result_low_r;
                `ACS_OFS_PIN_LOW:  hrdata_r[7:0] <= pin_low_r;
                // R5: top bit reads zero
                `ACS_OFS_PIN_HIGH: hrdata_r[7:0] <= pin_high_r;
                `ACS_OFS_FLAGS:    hrdata_r[0]   <= done_r;
                default:           hrdata_r      <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = !(req_r.rd && !rd_wait_r);
    assign hresp     = 1'b0;

    // R3: analog select bits set on reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_low_r  <= `ACS_RST_PIN_LOW;
            pin_high_r <= `ACS_RST_PIN_HIGH;
        end else if (ce && wr_fire) begin
            if (req_r.addr == `ACS_OFS_PIN_LOW) begin
                pin_low_r <= wdat;
            end
            if (req_r.addr == `ACS_OFS_PIN_HIGH) begin
                pin_high_r <= wdat & `ACS_PIN_HIGH_MASK;
            end
        end
    end

    // R10: configuration back to reset values, converter off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl1_r <= `ACS_RST_CTRL;
            ctrl2_r <= `ACS_RST_CTRL;
        end else if (ce && wr_fire) begin
            if (req_r.addr == `ACS_OFS_CTRL1) begin
                ctrl1_r <= wdat;
            end
            if (req_r.addr == `ACS_OFS_CTRL2) begin
                ctrl2_r <= wdat & 8'hBF;
            end
        end
    end

    // Go flag: hardware clears, a software write in the same cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl0_r <= `ACS_RST_CTRL;
        end else if (ce) begin
            // R9: go cleared at completion
            if (conv_end) begin
                ctrl0_r[`ACS_BIT_GO] <= 1'b0;
            end
            if (wr_fire && req_r.addr == `ACS_OFS_CTRL0) begin
                ctrl0_r <= {1'b0, wdat[6:0]};
                // Go only sticks while the converter is on
                ctrl0_r[`ACS_BIT_GO] <= wdat[`ACS_BIT_GO]
                                        && wdat[`ACS_BIT_ON];
            end
        end
    end

    // Done flag: write one clears, completion wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_r <= 1'b0;
        end else if (ce) begin
            if (wr_fire && req_r.addr == `ACS_OFS_FLAGS
                && wdat[`ACS_BIT_DONE]) begin
                done_r <= 1'b0;
            end
            // R19: done set on completion
            if (conv_end) begin
                done_r <= 1'b1;
            end
        end
    end

    assign conversion_done_flag = done_r;

    // R11: result pair has no reset, keeps contents across reset
    always_ff @(posedge hclk) begin
        if (ce) begin
            // R9: result loaded at completion
            if (conv_end) begin
                conversion_result_high_r <= res_word[15:8];
                conversion_result_low_r  <= res_word[7:0];
            end else if (wr_fire) begin
                if (req_r.addr == `ACS_OFS_RES_HIGH) begin
                    conversion_result_high_r <= wdat;
                end
                if (req_r.addr == `ACS_OFS_RES_LOW) begin
                    conversion_result_low_r <= wdat;
                end
            end
        end
    end

    // Justification bit selects right or left placement
    assign res_word = ctrl2_r[7] ? {4'h0, sar_r} : {sar_r, 4'h0};

    // R25: conversion clock from system divider or RC tick
    // R8: system-derived clock stops in sleep, only RC keeps converting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r <= 6'h00;
        end else if (ce) begin
            if (div_r >= tad_limit(conversion_clock_select)) begin
                div_r <= 6'h00;
            end else begin
                div_r <= div_r + 6'h01;
            end
        end
    end

    assign tad_tick = (conversion_clock_select[1:0] == 2'b11) ? rc_tick
                    : (!sleep_mode && div_r >= tad_limit(conversion_clock_select));

    assign run_ok   = ctrl0_r[`ACS_BIT_ON] && ctrl0_r[`ACS_BIT_GO];
    // R23: fourteenth period ends the conversion
    assign conv_end = (st_r == ACS_CONV) && tad_tick && run_ok
                      && (tad_cnt_r == 5'({`ACS_CONV_TADS} - 4'h1));

    // R20: state is internal only; go stays high through acquisition
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r      <= ACS_IDLE;
            tad_cnt_r <= 5'h00;
        end else if (ce) begin
            unique case (st_r)
                ACS_IDLE: begin
                    tad_cnt_r <= 5'h00;
                    if (run_ok) begin
                        // R17: code zero converts at once
                        // R18: else sample programmed periods first
                        st_r <= (acquisition_time_select == 3'b000) ? ACS_CONV : ACS_ACQ;
                    end
                end
                ACS_ACQ: begin
                    if (!run_ok) begin
                        st_r      <= ACS_WAIT;
                        tad_cnt_r <= 5'h00;
                    end else if (tad_tick) begin
                        // R24: programmed acquisition length
                        if (tad_cnt_r == acq_tads(acquisition_time_select) - 5'h01) begin
                            st_r      <= ACS_CONV;
                            tad_cnt_r <= 5'h00;
                        end else begin
                            tad_cnt_r <= tad_cnt_r + 5'h01;
                        end
                    end
                end
                ACS_CONV: begin
                    // R26: clearing go aborts, result untouched
                    if (!run_ok || conv_end) begin
                        st_r      <= ACS_WAIT;
                        tad_cnt_r <= 5'h00;
                    end else if (tad_tick) begin
                        tad_cnt_r <= tad_cnt_r + 5'h01;
                    end
                end
                ACS_WAIT: begin
                    // R14: two periods before sampling resumes
                    if (tad_tick) begin
                        if (tad_cnt_r == `ACS_WAIT_TADS - 5'h01) begin
                            st_r      <= ACS_IDLE;
                            tad_cnt_r <= 5'h00;
                        end else begin
                            tad_cnt_r <= tad_cnt_r + 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    // R21: successive approximation, one bit per period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sar_r <= 12'h000;
        end else if (ce) begin
            if (st_r != ACS_CONV) begin
                sar_r <= `ACS_SAR_TOP;
            end else if (tad_tick && tad_cnt_r < 5'({`ACS_SAR_BITS})) begin
                if (!cmp_in) begin
                    sar_r <= sar_r & ~(`ACS_SAR_TOP >> tad_cnt_r);
                end
                if (tad_cnt_r < 5'({`ACS_SAR_BITS} - 4'h1)) begin
                    sar_r[10 - tad_cnt_r] <= 1'b1;
                end
            end
        end
    end

    // R15: hold capacitor connected only outside conversion
    // R19: sampling resumes once idle again
    assign ana.sample   = ctrl0_r[`ACS_BIT_ON]
                          && (st_r == ACS_IDLE || st_r == ACS_ACQ);
    assign ana.pos_ch   = ctrl0_r[6:2];
    // R22: mux switches all open for code 28
    assign ana.mux_open = (ctrl0_r[6:2] == `ACS_MUX_OPEN_CODE);
    assign ana.neg_ch   = ctrl1_r[2:0];
    // R7: reference selection
    assign ana.vref_pos = ctrl1_r[5:4];
    assign ana.vref_neg = ctrl1_r[3];
    assign ana.dac      = sar_r;

    // R4: low bits map channels 7-0; R5: high bits map 14-8
    // R6: missing channels on small package ignore their bits
    assign sel_eff = {pin_high_r[6:0], pin_low_r}
                     & ~(small_pkg ? `ACS_SMALL_PKG_MASK : 15'h0000);

    // R1: cleared bit gives plain digital pin
    // R2: set bit routes analog, digital off, reads zero
    assign pin_analog_en = sel_eff;
    assign pin_dig_en    = ~sel_eff;
    assign pin_dig_rd    = pin_din & ~sel_eff;

endmodule
`default_nettype wire

// File: testbench/acs_top_sva.sv
// Port-level assertions for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
`include "acs_defines.svh"
module acs_top_sva
    import acs_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        small_pkg,
    input wire logic [14:0] pin_din,
    input wire logic [14:0] pin_dig_rd,
    input wire logic [14:0] pin_analog_en,
    input wire logic [14:0] pin_dig_en,
    input wire acs_ana_t    ana,
    input wire logic        conversion_done_flag
);
    logic [7:0] low_cnt_r;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Saturating, so a long idle with the switch open cannot wrap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) low_cnt_r <= 8'h00;
        else if (ana.sample) low_cnt_r <= 8'h00;
        else if (low_cnt_r != 8'hFF) low_cnt_r <= low_cnt_r + 8'h01;
    end
    sequence s_rd_req;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_wait: assert property (s_rd_req |=> s_one_wait)
        else $error("read data phase not one wait state");
    a_dig_en_inv: assert property (pin_dig_en == ~pin_analog_en)
        else $error("digital enable not inverse of analog select");
    a_dig_rd_zero: assert property (
        pin_dig_rd == (pin_din & ~pin_analog_en))
        else $error("analog pin digital read not zero");
    a_small_pkg_off: assert property (
        small_pkg |-> (pin_analog_en & `ACS_SMALL_PKG_MASK) == 15'h0000)
        else $error("absent channel select took effect");
    a_mux_open: assert property (
        ana.pos_ch == `ACS_MUX_OPEN_CODE |-> ana.mux_open)
        else $error("mux not opened for disconnect code");
    a_conv_length: assert property (
        $rose(conversion_done_flag) |-> low_cnt_r >= 8'h18)
        else $error("conversion ended too soon or hold closed");
    a_rewait_gap: assert property (
        $rose(conversion_done_flag) |-> !ana.sample [*3])
        else $error("sampling resumed without wait");
    a_reset_state: assert property (
        $rose(hresetn) |-> !conversion_done_flag &&
        (pin_analog_en | `ACS_SMALL_PKG_MASK) == 15'h7FFF)
        else $error("state after reset wrong");
endmodule
bind acs_top acs_top_sva u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .small_pkg(small_pkg), .pin_din(pin_din), .pin_dig_rd(pin_dig_rd),
    .pin_analog_en(pin_analog_en), .pin_dig_en(pin_dig_en), .ana(ana),
    .conversion_done_flag(conversion_done_flag));
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
`include "acs_defines.svh"
module tb
    import acs_pkg::*;
;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        small_pkg = 1'b0, sleep_mode = 1'b0;
    logic        rc_tick = 1'b0, cmp_in = 1'b0;
    logic        hready, hreadyout, hresp, conversion_done_flag;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, rc_div = 3'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [14:0] pin_din = 15'h2AD5, pin_dig_rd, pin_analog_en, pin_dig_en;
    logic [11:0] vin = 12'h000, last;
    acs_ana_t    ana;
    int          err_total = 0, checks = 0, n;
    int          acq_tab [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int          tad_tab [8] = '{2, 8, 32, 5, 4, 16, 64, 5};
    assign hready = hreadyout;
    acs_top uut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .small_pkg(small_pkg),
        .sleep_mode(sleep_mode), .rc_tick(rc_tick), .cmp_in(cmp_in),
        .pin_din(pin_din), .pin_dig_rd(pin_dig_rd),
        .pin_analog_en(pin_analog_en), .pin_dig_en(pin_dig_en),
        .ana(ana), .conversion_done_flag(conversion_done_flag));
    initial forever #25 hclk = ~hclk;
    // Ideal comparator one cycle behind the trial value
    always @(posedge hclk) begin
        rc_div <= (rc_div == 3'h4) ? 3'h0 : rc_div + 3'h1;
        rc_tick <= (rc_div == 3'h4);
        cmp_in <= (vin >= ana.dac);
    end
    task automatic complete_run();
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rng(input int v, input int lo, input int hi);
        chk(32'(v), 32'(v < lo ? lo : (v > hi ? hi : v)));
    endtask
    // Entered just after a rising edge; returns at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        logic ok;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do begin
            @(negedge hclk);
            ok = hreadyout;
            @(posedge hclk);
        end while (ok !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(negedge hclk);
            ok = hreadyout;
            q = hrdata;
            @(posedge hclk);
        end while (ok !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic conv(input logic [2:0] acq, input logic [2:0] ck,
                        input logic rj, input int tad);
        sleep_mode <= (ck[1:0] == 2'h3);
        vin <= vin + 12'h5A3;
        bus(1'b1, `ACS_OFS_CTRL2, {24'h0, rj, 1'b0, acq, ck});
        bus(1'b1, `ACS_OFS_CTRL0, 32'h3);
        for (int p = 0; p < 3; p++) begin
            n = 0;
            while (n < 2000 && (p == 0 ? ana.sample !== 1'b0 : p == 1 ?
                   conversion_done_flag !== 1'b1 : ana.sample !== 1'b1)) begin
                @(negedge hclk);
                n++;
            end
            if (p == 0) rng(n, acq_tab[acq] * tad - tad, acq_tab[acq] * tad + 3);
            if (p == 1) rng(n, 13 * tad, 14 * tad + 3);
            if (p == 2) rng(n, tad, 2 * tad + 3);
        end
        @(posedge hclk);
        rd(`ACS_OFS_CTRL0, 32'h1);
        rd(`ACS_OFS_FLAGS, 32'h1);
        rd(`ACS_OFS_RES_HIGH, {24'h0, rj ? {4'h0, vin[11:8]} : vin[11:4]});
        rd(`ACS_OFS_RES_LOW, {24'h0, rj ? vin[7:0] : {vin[3:0], 4'h0}});
        bus(1'b1, `ACS_OFS_FLAGS, 32'h1);
        rd(`ACS_OFS_FLAGS, 32'h0);
        last = vin;
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`ACS_OFS_PIN_LOW, 32'hFF);
        rd(`ACS_OFS_PIN_HIGH, 32'h7F);
        bus(1'b1, `ACS_OFS_PIN_LOW, 32'h5A);
        bus(1'b1, `ACS_OFS_PIN_HIGH, 32'hFF);
        rd(`ACS_OFS_PIN_HIGH, 32'h7F);
        @(negedge hclk);
        chk({17'h0, pin_analog_en}, 32'h7F5A);
        chk({17'h0, pin_dig_rd}, {17'h0, pin_din & 15'h00A5});
        @(posedge hclk);
        small_pkg <= 1'b1;
        @(negedge hclk);
        chk({17'h0, pin_analog_en}, 32'h071A);
        @(posedge hclk);
        rd(`ACS_OFS_PIN_HIGH, 32'h7F);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `ACS_OFS_CTRL1, 32'(i * 16 + 8 + i));
            @(negedge hclk);
            chk({29'h0, ana.vref_pos, ana.vref_neg}, 32'(i * 2 + 1));
            chk({29'h0, ana.neg_ch}, 32'(i));
            @(posedge hclk);
        end
        bus(1'b1, `ACS_OFS_CTRL0, 32'h71);
        @(negedge hclk);
        chk({31'h0, ana.mux_open}, 32'h1);
        @(posedge hclk);
        rd(8'h40, 32'h0);
        bus(1'b1, `ACS_OFS_CTRL0, 32'h1);
        for (int i = 0; i < 8; i++) conv(3'(i), 3'h1, 1'b0, 8);
        for (int i = 0; i < 8; i++) conv(3'h0, 3'(i), i[0], tad_tab[i]);
        // A new input level shows whether the aborted run wrote back
        vin <= ~vin;
        bus(1'b1, `ACS_OFS_CTRL0, 32'h3);
        repeat (40) @(posedge hclk);
        bus(1'b1, `ACS_OFS_CTRL0, 32'h1);
        repeat (150) @(posedge hclk);
        rd(`ACS_OFS_FLAGS, 32'h0);
        rd(`ACS_OFS_RES_LOW, {24'h0, last[7:0]});
        bus(1'b1, `ACS_OFS_CTRL0, 32'h3);
        repeat (40) @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        rd(`ACS_OFS_CTRL0, 32'h0);
        rd(`ACS_OFS_PIN_LOW, 32'hFF);
        repeat (300) @(posedge hclk);
        rd(`ACS_OFS_FLAGS, 32'h0);
        bus(1'b1, `ACS_OFS_CTRL2, 32'h81);
        rd(`ACS_OFS_RES_LOW, {24'h0, last[7:0]});
        complete_run();
    end
    initial begin
        #(20000 * 50);
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
